// ==== core/input_conditioning_defs.vh ====
`ifndef INPUT_CONDITIONING_DEFS_VH
`define INPUT_CONDITIONING_DEFS_VH
// input function codes
`define FN_NONE 7'h00
`define FN_FWD_RUN 7'h02
`define FN_FORCED_STOP 7'h0A
`define FN_ALARM_RESET 7'h0B
`define FN_DEV_CLEAR 7'h0C
`define FN_FREE_RUN 7'h36
`define FN_POS_OVERTRAVEL 7'h07
`define FN_NEG_OVERTRAVEL 7'h08
`define FN_REGEN_OVERHEAT 7'h22
`define FN_BCAST_CANCEL 7'h4E
`define FN_MAX 7'h4E
// parameter ranges and reset values
`define ZERO_CLAMP_MAX 16'h01F4
`define ZERO_CLAMP_RESET 16'h0000
`define FINE_GAIN_MIN 16'h1F40
`define FINE_GAIN_MAX 16'h2EE0
`define FINE_GAIN_RESET 16'h2710
`define FINE_GAIN_ONE 16'h2710
`define SPD_OFS_MIN 16'hF830
`define SPD_OFS_MAX 16'h07D0
`define TRQ_OFS_MIN 16'hFE0C
`define TRQ_OFS_MAX 16'h01F4
`define TRQ_OFS_UNIT 16'h000A
`define SCALE_MIN 16'h000A
`define SCALE_MAX 16'h03E8
`define SCALE_RESET 16'h0032
`define DEV_FMT_EDGE 1'b0
`define DEV_FMT_LEVEL 1'b1
`define VIRT_RESET 8'h00
`define SLOT_RESET 7'h00
// control modes
`define MODE_POSITION 2'h0
`define MODE_SPEED 2'h1
`define MODE_TORQUE 2'h2
`endif

// ==== core/fine_gain_mult.v ====
`include "input_conditioning_defs.vh"

// signed command times a gain in 1/10000 units, one cycle latency
module fine_gain_mult #(
    parameter WIDTH = 16
) (
    input wire mclk,
    input wire rst_b,
    input wire signed [WIDTH-1:0] value,
    input wire [15:0] gain,
    output reg signed [WIDTH-1:0] result
);
    wire signed [WIDTH+17:0] product;
    wire signed [WIDTH+17:0] scaled;
    wire signed [WIDTH+17:0] top;
    wire signed [WIDTH+17:0] bot;

    // 18 bits of headroom; a gain up to 1.2 can still push large values past the rails, so saturation is live
    assign product = value * $signed({2'b00, gain});
    assign scaled = product / $signed({{(WIDTH+2){1'b0}}, `FINE_GAIN_ONE});
    assign top = {{18{1'b0}}, 1'b0, {(WIDTH-1){1'b1}}};
    assign bot = ~top;

    always @(posedge mclk) begin
        if (!rst_b) begin
            result <= {WIDTH{1'b0}};
        end else if (scaled > top) begin
            result <= top[WIDTH-1:0];
        end else if (scaled < bot) begin
            result <= bot[WIDTH-1:0];
        end else begin
            result <= scaled[WIDTH-1:0];
        end
    end
endmodule // fine_gain_mult

// ==== core/input_terminal_conditioning.v ====
// Function
// RQ1 - broadcast-cancel on: drop broadcast queries silently, unicast still accepted
// RQ2 - unassigned input functions read OFF, so broadcasts accepted by default
// RQ3 - broadcast-cancel in a forced-on slot disables broadcast reception permanently
// RQ4 - virtual input byte ORed onto terminals, bit0 to terminal one
// RQ5 - five forced-on slots, codes 0..78; open asserted, closed deasserted
// RQ6 - alarm reset, deviation clear, free-run cannot be forced on
// RQ7 - only overtravel closed functions may be forced; others rejected
// RQ8 - a function may sit on a terminal and a slot together
// RQ9 - slots and deviation-clear format take effect only after power-up
// RQ10 - zero clamp only in speed or position control mode
// RQ11 - speed under clamp level forced to zero, level 0..500 default 0
// RQ12 - clamp decision made after offset so drift cannot move motor
// RQ13 - edge format clears deviation once at the active edge
// RQ14 - level format holds deviation at zero while input asserted
// RQ15 - speed command times fine gain 0.8..1.2, default 1.0
// RQ16 - torque command times separate fine gain 0.8..1.2
// RQ17 - offsets added: speed -2000..2000 mV, torque -500..500 times 10 mV
// RQ18 - speed scale 1.0..100.0 V either sign, default 5.0
// RQ19 - function state is terminal OR virtual bit OR forced slot
`include "input_conditioning_defs.vh"

module input_terminal_conditioning #(
    parameter NUM_TERM = 8,
    parameter NUM_SLOT = 5,
    parameter CMD_W = 16
) (
    input wire mclk,
    input wire rst_b,
    // physical terminal pins and their assigned function codes
    input wire [NUM_TERM-1:0] logic_input_terminal,
    input wire [NUM_TERM*7-1:0] terminal_function,
    input wire [7:0] virtual_input_byte,
    // forced-on slots, written any time, loaded at power-up only
    input wire [NUM_SLOT*7-1:0] forced_slot_code,
    input wire power_up,
    input wire deviation_clear_format,
    // host query classification from the serial receiver
    input wire query_valid,
    input wire query_broadcast,
    input wire query_own_station,
    input wire [1:0] control_mode,
    input wire [15:0] zero_clamp_level,
    input wire [15:0] speed_fine_gain,
    input wire [15:0] torque_fine_gain,
    input wire signed [15:0] speed_offset_mv,
    input wire signed [15:0] torque_offset,
    input wire signed [15:0] speed_scale,
    input wire signed [CMD_W-1:0] analog_speed_sample,
    input wire signed [CMD_W-1:0] analog_torque_reference,
    input wire [15:0] rated_speed,
    output reg query_accept,
    output reg broadcast_disabled,
    output reg deviation_clear,
    output reg forward_run_command,
    output reg positive_overtravel,
    output reg negative_overtravel,
    output reg signed [CMD_W-1:0] speed_command,
    output reg signed [CMD_W-1:0] torque_command,
    output reg [NUM_SLOT-1:0] slot_rejected
);
    // two-flop synchroniser for the pins
    reg [NUM_TERM-1:0] term_meta;
    reg [NUM_TERM-1:0] term_sync;
    always @(posedge mclk) begin
        if (!rst_b) begin
            term_meta <= {NUM_TERM{1'b0}};
            term_sync <= {NUM_TERM{1'b0}};
        end else begin
            term_meta <= logic_input_terminal;
            term_sync <= term_meta;
        end
    end

    // terminal state merged with virtual byte
    wire [NUM_TERM-1:0] term_eff;
    assign term_eff = term_sync | virtual_input_byte[NUM_TERM-1:0]; // RQ4

    // latched slot codes and power-time format
    reg [NUM_SLOT*7-1:0] slot_live;
    reg fmt_live;
    reg [NUM_SLOT-1:0] next_reject;
    integer k;
    reg [6:0] code;
    always @* begin
        next_reject = {NUM_SLOT{1'b0}};
        code = 7'h00;
        for (k = 0; k < NUM_SLOT; k = k + 1) begin
            code = forced_slot_code[k*7 +: 7];
            if (code > `FN_MAX || code == `FN_ALARM_RESET || code == `FN_DEV_CLEAR ||
                code == `FN_FREE_RUN) begin // RQ5 RQ6
                next_reject[k] = 1'b1;
            end else if (code == `FN_FORCED_STOP || code == `FN_REGEN_OVERHEAT) begin // RQ7
                next_reject[k] = 1'b1;
            end
        end
    end

    // own loop index, so the combinational slot check keeps sole use of k
    integer j;
    // new settings only reach the logic at power-up, not on write
    always @(posedge mclk) begin
        if (!rst_b) begin
            slot_live <= {NUM_SLOT{`SLOT_RESET}};
            fmt_live <= `DEV_FMT_EDGE;
            slot_rejected <= {NUM_SLOT{1'b0}};
        end else if (power_up) begin // RQ9
            fmt_live <= deviation_clear_format;
            slot_rejected <= next_reject;
            for (j = 0; j < NUM_SLOT; j = j + 1) begin
                slot_live[j*7 +: 7] <= next_reject[j] ? `FN_NONE : forced_slot_code[j*7 +: 7];
            end
        end
    end

    // function resolution: one test per terminal and slot
    function func_on;
        input [6:0] fn;
        input [NUM_TERM-1:0] st;
        input [NUM_TERM*7-1:0] map;
        integer i;
        begin
            func_on = 1'b0;
            for (i = 0; i < NUM_TERM; i = i + 1) begin
                if (map[i*7 +: 7] == fn && st[i]) begin
                    func_on = 1'b1; // RQ2 RQ19
                end
            end
        end
    endfunction

    function func_forced;
        input [6:0] fn;
        input [NUM_SLOT*7-1:0] slots;
        integer i;
        begin
            func_forced = 1'b0;
            for (i = 0; i < NUM_SLOT; i = i + 1) begin
                if (slots[i*7 +: 7] == fn) begin
                    func_forced = 1'b1;
                end
            end
        end
    endfunction

    // a slot and a terminal may name the same function; OR keeps both valid
    wire bc_on = func_on(`FN_BCAST_CANCEL, term_eff, terminal_function) |
                 func_forced(`FN_BCAST_CANCEL, slot_live); // RQ3 RQ8 RQ19
    wire fwd_on = func_on(`FN_FWD_RUN, term_eff, terminal_function) |
                  func_forced(`FN_FWD_RUN, slot_live); // RQ19
    wire dc_on = func_on(`FN_DEV_CLEAR, term_eff, terminal_function); // RQ6
    // overtravel is normally closed: a forced slot holds the contact deasserted
    wire pot_on = func_on(`FN_POS_OVERTRAVEL, term_eff, terminal_function) &
                  ~func_forced(`FN_POS_OVERTRAVEL, slot_live); // RQ5 RQ7
    wire not_on = func_on(`FN_NEG_OVERTRAVEL, term_eff, terminal_function) &
                  ~func_forced(`FN_NEG_OVERTRAVEL, slot_live); // RQ5 RQ7

    // query gate: broadcast dropped without reply while cancel is on
    always @(posedge mclk) begin
        if (!rst_b) begin
            query_accept <= 1'b0;
            broadcast_disabled <= 1'b0;
        end else begin
            broadcast_disabled <= bc_on; // RQ1 RQ3
            if (query_valid && query_broadcast) begin
                query_accept <= ~bc_on; // RQ1 RQ2
            end else begin
                query_accept <= query_valid & query_own_station; // RQ1
            end
        end
    end

    // deviation clear, edge or level per power-up format
    reg dc_prev;
    always @(posedge mclk) begin
        if (!rst_b) begin
            dc_prev <= 1'b0;
            deviation_clear <= 1'b0;
            forward_run_command <= 1'b0;
            positive_overtravel <= 1'b0;
            negative_overtravel <= 1'b0;
        end else begin
            dc_prev <= dc_on;
            if (fmt_live == `DEV_FMT_LEVEL) begin
                deviation_clear <= dc_on; // RQ14
            end else begin
                deviation_clear <= dc_on & ~dc_prev; // RQ13
            end
            forward_run_command <= fwd_on;
            positive_overtravel <= pot_on;
            negative_overtravel <= not_on;
        end
    end

    // clamp parameter ranges; out-of-range values pinned to the limits
    function signed [15:0] lim;
        input signed [15:0] v;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            lim = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    wire [15:0] spd_gain = (speed_fine_gain < `FINE_GAIN_MIN) ? `FINE_GAIN_MIN :
                           ((speed_fine_gain > `FINE_GAIN_MAX) ? `FINE_GAIN_MAX : speed_fine_gain);
    wire [15:0] trq_gain = (torque_fine_gain < `FINE_GAIN_MIN) ? `FINE_GAIN_MIN :
                           ((torque_fine_gain > `FINE_GAIN_MAX) ? `FINE_GAIN_MAX : torque_fine_gain);
    wire [15:0] clamp_lvl = (zero_clamp_level > `ZERO_CLAMP_MAX) ? `ZERO_CLAMP_MAX : zero_clamp_level;
    wire signed [15:0] spd_ofs = lim(speed_offset_mv, `SPD_OFS_MIN, `SPD_OFS_MAX);
    wire signed [15:0] trq_ofs = lim(torque_offset, `TRQ_OFS_MIN, `TRQ_OFS_MAX);
    wire [15:0] scale_mag = speed_scale[15] ? (16'h0000 - speed_scale) : speed_scale;
    wire [15:0] scale_abs = (scale_mag < `SCALE_MIN) ? `SCALE_MIN :
                            ((scale_mag > `SCALE_MAX) ? `SCALE_MAX : scale_mag); // RQ18

    // stage 1: offset added in millivolts
    reg signed [CMD_W-1:0] spd_mv;
    reg signed [CMD_W-1:0] trq_mv;
    wire signed [CMD_W+1:0] spd_sum = analog_speed_sample + spd_ofs;
    wire signed [CMD_W+1:0] trq_sum = analog_torque_reference + (trq_ofs * $signed(`TRQ_OFS_UNIT));
    always @(posedge mclk) begin
        if (!rst_b) begin
            spd_mv <= {CMD_W{1'b0}};
            trq_mv <= {CMD_W{1'b0}};
        end else begin
            spd_mv <= spd_sum[CMD_W-1:0]; // RQ17
            trq_mv <= trq_sum[CMD_W-1:0]; // RQ17
        end
    end

    // stage 2: fine gain
    wire signed [CMD_W-1:0] spd_gained;
    wire signed [CMD_W-1:0] trq_gained;
    fine_gain_mult #(.WIDTH(CMD_W)) u_spd_gain (
        .mclk(mclk),
        .rst_b(rst_b),
        .value(spd_mv),
        .gain(spd_gain), // RQ15
        .result(spd_gained)
    );
    fine_gain_mult #(.WIDTH(CMD_W)) u_trq_gain (
        .mclk(mclk),
        .rst_b(rst_b),
        .value(trq_mv),
        .gain(trq_gain), // RQ16
        .result(trq_gained)
    );

    // stage 3: mV to r/min via scale (0.1 V units per rated speed)
    wire signed [CMD_W+33:0] rpm_prod = spd_gained * $signed({1'b0, rated_speed});
    wire signed [CMD_W+33:0] rpm_wide = rpm_prod /
        $signed({{(CMD_W+2){1'b0}}, scale_abs, 16'h0000} >>> 16) / $signed({{(CMD_W+18){1'b0}}, 16'h0064});
    wire signed [CMD_W-1:0] rpm_raw = speed_scale[15] ? -rpm_wide[CMD_W-1:0] : rpm_wide[CMD_W-1:0];
    wire [CMD_W-1:0] rpm_mag = rpm_raw[CMD_W-1] ? ({CMD_W{1'b0}} - rpm_raw) : rpm_raw;
    wire clamp_mode = (control_mode == `MODE_SPEED) || (control_mode == `MODE_POSITION); // RQ10

    // clamp tested on the final command, after offset, so drift stays at zero
    always @(posedge mclk) begin
        if (!rst_b) begin
            speed_command <= {CMD_W{1'b0}};
            torque_command <= {CMD_W{1'b0}};
        end else begin
            if (clamp_mode && (rpm_mag < clamp_lvl[CMD_W-1:0])) begin // RQ11 RQ12
                speed_command <= {CMD_W{1'b0}};
            end else begin
                speed_command <= rpm_raw;
            end
            torque_command <= trq_gained;
        end
    end
endmodule // input_terminal_conditioning

// ==== tb/input_conditioning_sva.sv ====
`include "input_conditioning_defs.vh"
module input_conditioning_chk #(
    parameter NUM_TERM = 8,
    parameter NUM_SLOT = 5,
    parameter CMD_W = 16
) (
    input wire mclk,
    input wire rst_b,
    input wire [NUM_TERM*7-1:0] terminal_function,
    input wire [7:0] virtual_input_byte,
    input wire [NUM_SLOT*7-1:0] forced_slot_code,
    input wire power_up,
    input wire deviation_clear_format,
    input wire query_valid,
    input wire query_broadcast,
    input wire query_own_station,
    input wire [1:0] control_mode,
    input wire [15:0] zero_clamp_level,
    input wire query_accept,
    input wire broadcast_disabled,
    input wire deviation_clear,
    input wire forward_run_command,
    input wire signed [CMD_W-1:0] speed_command
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic fmt;
    logic has_bc;
    logic [2:0] calm;
    wire [CMD_W-1:0] mag = speed_command[CMD_W-1] ? -speed_command : speed_command;
    // any slot asking for broadcast cancel
    always_comb begin
        has_bc = 1'b0;
        for (int k = 0; k < NUM_SLOT; k++) has_bc = has_bc | (forced_slot_code[7*k+:7] == `FN_BCAST_CANCEL);
    end
    // format as latched at power-up; calm counts cycles with clamp inputs unchanged, so old results drain first
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fmt <= `DEV_FMT_EDGE;
            calm <= 3'h0;
        end else begin
            if (power_up) fmt <= deviation_clear_format;
            if ($changed(control_mode) || $changed(zero_clamp_level)) calm <= 3'h0;
            else if (calm != 3'h7) calm <= calm + 3'h1;
        end
    end
    chk_unicast_taken: assert property (query_valid && !query_broadcast && query_own_station |=> query_accept)
        else $error("own-station query not accepted");
    chk_foreign_dropped: assert property (
        query_valid && !query_broadcast && !query_own_station |=> !query_accept)
        else $error("foreign query accepted");
    chk_bcast_dropped: assert property (
        query_valid && query_broadcast && broadcast_disabled ##1 broadcast_disabled |-> !query_accept)
        else $error("broadcast accepted while cancelled");
    chk_bcast_passed: assert property (
        query_valid && query_broadcast && !broadcast_disabled ##1 !broadcast_disabled |-> query_accept)
        else $error("broadcast dropped while enabled");
    chk_no_query_silent: assert property (!query_valid |=> !query_accept)
        else $error("accept without a query");
    chk_forced_cancel_held: assert property ($fell(power_up) && has_bc |-> ##[1:4] broadcast_disabled [*4])
        else $error("forced cancel not holding broadcasts off");
    chk_clamp_floor_kept: assert property (
        calm >= 3'h4 && (control_mode == `MODE_SPEED || control_mode == `MODE_POSITION) && speed_command != 0
        |-> mag >= (zero_clamp_level > `ZERO_CLAMP_MAX ? `ZERO_CLAMP_MAX : zero_clamp_level))
        else $error("speed below clamp level not zeroed");
    chk_edge_one_pulse: assert property (!fmt && deviation_clear |=> !deviation_clear)
        else $error("edge clear longer than one cycle");
    chk_virtual_bit_zero: assert property ((virtual_input_byte[0] && terminal_function[6:0] == `FN_FWD_RUN) [*4]
        |-> forward_run_command)
        else $error("virtual bit zero not driving terminal one");
    cover property (query_valid && query_broadcast && broadcast_disabled);
    cover property ($fell(power_up) && has_bc);
    cover property (fmt && deviation_clear [*4]);
endmodule // input_conditioning_chk

bind input_terminal_conditioning input_conditioning_chk #(
    .NUM_TERM(NUM_TERM),
    .NUM_SLOT(NUM_SLOT),
    .CMD_W(CMD_W)
) chk_i (
    .mclk(mclk),
    .rst_b(rst_b),
    .terminal_function(terminal_function),
    .virtual_input_byte(virtual_input_byte),
    .forced_slot_code(forced_slot_code),
    .power_up(power_up),
    .deviation_clear_format(deviation_clear_format),
    .query_valid(query_valid),
    .query_broadcast(query_broadcast),
    .query_own_station(query_own_station),
    .control_mode(control_mode),
    .zero_clamp_level(zero_clamp_level),
    .query_accept(query_accept),
    .broadcast_disabled(broadcast_disabled),
    .deviation_clear(deviation_clear),
    .forward_run_command(forward_run_command),
    .speed_command(speed_command)
);

// ==== tb/host_query_model.sv ====
module host_query_model (
    input wire logic mclk,
    output logic query_valid = 1'b0,
    output logic query_broadcast = 1'b0,
    output logic query_own_station = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // one query held for one clock, called just after a falling edge
    task automatic send(input logic b, input logic o);
        query_valid = 1'b1;
        query_broadcast = b;
        query_own_station = o;
        @(negedge mclk);
    endtask
    // lines mean nothing between queries, so show the inverse rather than stale values
    task automatic idle;
        query_valid = 1'b0;
        query_broadcast = ~query_broadcast;
        query_own_station = ~query_own_station;
    endtask
endmodule // host_query_model

// ==== tb/input_terminal_conditioning_bench.sv ====
`include "input_conditioning_defs.vh"
module input_terminal_conditioning_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b, power_up, deviation_clear_format, cancel;
    logic [7:0] logic_input_terminal, virtual_input_byte;
    logic [55:0] terminal_function;
    logic [34:0] forced_slot_code;
    logic [1:0] control_mode;
    logic [15:0] zero_clamp_level, speed_fine_gain, torque_fine_gain, rated_speed, exp_q[$];
    logic signed [15:0] speed_offset_mv, torque_offset, speed_scale, analog_speed_sample, analog_torque_reference;
    wire query_valid, query_broadcast, query_own_station, query_accept, broadcast_disabled;
    wire deviation_clear, forward_run_command, positive_overtravel, negative_overtravel;
    wire signed [15:0] speed_command, torque_command;
    wire [4:0] slot_rejected;
    logic qv1 = 1'b0;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int dcnt = 0;
    int seed = 32'h763F5CA0;
    input_terminal_conditioning DUT (.*);
    host_query_model host (.*);
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // slots and format only land on a power-up
    task automatic pwr;
        power_up = 1'b1;
        cyc(1);
        power_up = 1'b0;
        cyc(4);
    endtask
    // back-to-back random queries, each expectation noted as it goes out
    task automatic qburst;
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            exp_q.push_back({15'h0, r[0] ? !cancel : r[1]});
            host.send(r[0], r[1]);
        end
        host.idle;
        cyc(3);
    endtask
    task automatic spd(input logic [1:0] m, input logic [15:0] mv, ofs, lvl, exp);
        control_mode = m;
        analog_speed_sample = mv;
        speed_offset_mv = ofs;
        zero_clamp_level = lvl;
        cyc(3);
        chk(speed_command, exp);
    endtask
    task automatic trq(input logic [15:0] g, ofs, exp);
        torque_fine_gain = g;
        torque_offset = ofs;
        // offset, gain and output stages: three edges from input to port
        cyc(3);
        chk(torque_command, exp);
    endtask
    task automatic pulse_dev(input logic [15:0] exp);
        dcnt = 0;
        logic_input_terminal[1] = 1'b1;
        cyc(10);
        logic_input_terminal[1] = 1'b0;
        cyc(5);
        chk(dcnt[15:0], exp);
    endtask
    // answers arrive one cycle after the query edge; also counts clear cycles and cuts hangs
    always @(posedge mclk) begin
        qv1 <= query_valid;
    end
    always @(negedge mclk) begin
        if (qv1 === 1'b1 && exp_q.size() > 0) chk({15'h0, query_accept}, exp_q.pop_front());
        if (deviation_clear === 1'b1) dcnt++;
        cycles++;
        if (cycles > 3000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        {rst_b, power_up, deviation_clear_format, cancel, logic_input_terminal} = '0;
        {virtual_input_byte, terminal_function, forced_slot_code, zero_clamp_level} = '0;
        {speed_offset_mv, torque_offset, analog_speed_sample} = '0;
        control_mode = `MODE_SPEED;
        speed_fine_gain = `FINE_GAIN_RESET;
        torque_fine_gain = `FINE_GAIN_RESET;
        rated_speed = 16'h0BB8;
        speed_scale = `SCALE_RESET;
        analog_torque_reference = 16'h03E8;
        cyc(5);
        rst_b = 1'b1;
        pwr;
        qburst;
        terminal_function[55:49] = `FN_BCAST_CANCEL;
        logic_input_terminal[7] = 1'b1;
        cancel = 1'b1;
        cyc(4);
        qburst;
        logic_input_terminal[7] = 1'b0;
        cancel = 1'b0;
        $display("query test done");
        for (int i = 0; i < 8; i++) begin
            terminal_function = {49'h0, `FN_FWD_RUN} << (7 * i);
            virtual_input_byte = 8'h01 << i;
            cyc(4);
            chk({15'h0, forward_run_command}, 16'h0001);
        end
        virtual_input_byte = 8'h00;
        cyc(4);
        chk({15'h0, forward_run_command}, 16'h0000);
        $display("virtual input test done");
        terminal_function = {49'h0, `FN_FWD_RUN};
        forced_slot_code = {`FN_BCAST_CANCEL, `FN_REGEN_OVERHEAT, `FN_NEG_OVERTRAVEL, `FN_ALARM_RESET, `FN_FWD_RUN};
        cyc(4);
        chk({14'h0, broadcast_disabled, forward_run_command}, 16'h0000);
        pwr;
        cancel = 1'b1;
        chk({11'h0, slot_rejected}, 16'h000A);
        chk({14'h0, broadcast_disabled, forward_run_command}, 16'h0003);
        qburst;
        forced_slot_code = {`FN_POS_OVERTRAVEL, 7'h4F, `FN_FORCED_STOP, `FN_FREE_RUN, `FN_DEV_CLEAR};
        pwr;
        cancel = 1'b0;
        chk({11'h0, slot_rejected}, 16'h000F);
        // positive overtravel now forced by slot four, negative only from its terminal
        terminal_function[27:14] = {`FN_NEG_OVERTRAVEL, `FN_POS_OVERTRAVEL};
        virtual_input_byte = 8'h0C;
        cyc(4);
        chk({14'h0, positive_overtravel, negative_overtravel}, 16'h0001);
        virtual_input_byte = 8'h00;
        $display("forced slot test done");
        terminal_function[13:7] = `FN_DEV_CLEAR;
        deviation_clear_format = `DEV_FMT_LEVEL;
        pulse_dev(16'h0001);
        pwr;
        pulse_dev(16'h000A);
        $display("deviation clear test done");
        spd(`MODE_SPEED, 16'h1388, 16'h0000, 16'h0000, 16'h0BB8);
        spd(`MODE_SPEED, 16'h0064, 16'h0000, 16'h0064, 16'h0000);
        spd(`MODE_TORQUE, 16'h0064, 16'h0000, 16'h0064, 16'h003C);
        spd(`MODE_POSITION, 16'h0000, 16'h0064, 16'h0064, 16'h0000);
        spd(`MODE_SPEED, 16'h0000, 16'hFC18, 16'h0000, 16'hFDA8);
        spd(`MODE_SPEED, 16'hFF9C, 16'h0000, 16'h003C, 16'hFFC4);
        speed_fine_gain = `FINE_GAIN_MAX;
        spd(`MODE_SPEED, 16'h1388, 16'h0000, 16'h0000, 16'h0E10);
        speed_fine_gain = `FINE_GAIN_ONE;
        speed_scale = 16'h0064;
        spd(`MODE_SPEED, 16'h1388, 16'h0000, 16'h0000, 16'h05DC);
        trq(16'h2710, 16'h0000, 16'h03E8);
        trq(16'h2EE0, 16'h0000, 16'h04B0);
        trq(16'h1F40, 16'h0000, 16'h0320);
        trq(16'h2710, 16'h0032, 16'h05DC);
        trq(16'h2710, 16'hFE0C, 16'hF060);
        $display("analog test done");
        test_done;
    end
endmodule // input_terminal_conditioning_bench
